// *** cycle_timer.sv ***
// Down counter that marks the end of one conversion cycle period.
`timescale 1ns/1ps
module cycle_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] target,
  output logic expired
);
  import temp_cfg_pkg::*;

  timer_t q;
  timer_t n;

  always_comb begin
    n = q;
    if (start) begin
      // Loaded one short so that the next cycle starts exactly target edges after this one.
      n.count = target - 32'h1;
    end else if (q.count != 32'h0) begin
      n.count = q.count - 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign expired = (q.count == 32'h0);
endmodule // cycle_timer

// *** fe_model.sv ***
// Front end model that answers each conversion request with one raw sample.
`timescale 1ns/1ps
module fe_model #(
  parameter int DELAY = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic convStart,
  input wire logic [15:0] base,
  output temp_cfg_pkg::sample_t sample
);
  import temp_cfg_pkg::*;
  int waitCnt;
  logic phase;
  logic [15:0] lastData;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 0;
      phase <= 1'h0;
      lastData <= 16'h0000;
      sample <= '0;
    end else begin
      sample.valid <= 1'h0;
      sample.data <= ~lastData;
      if (convStart) begin
        waitCnt <= DELAY;
      end else if (waitCnt == 1) begin
        waitCnt <= 0;
        sample.valid <= 1'h1;
        sample.data <= phase ? base + 16'h0002 : base;
        lastData <= phase ? base + 16'h0002 : base;
        phase <= ~phase;
      end else if (waitCnt > 1) begin
        waitCnt <= waitCnt - 1;
      end
    end
  end
endmodule // fe_model

// *** sample_averager.sv ***
// Block averager: sums a fixed number of samples, then yields their mean once.
`timescale 1ns/1ps
`include "temp_cfg_defines.svh"
module sample_averager (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [1:0] sampleMeanSelect,
  input temp_cfg_pkg::sample_t sample,
  output logic needMore,
  output logic meanValid,
  output logic [15:0] mean
);
  import temp_cfg_pkg::*;

  avg_t q;
  avg_t n;
  logic [22:0] sumNext;

  always_comb begin
    n = q;
    n.meanValid = 1'b0;
    sumNext = q.sum + {{7{sample.data[15]}}, sample.data};
    if (clear) begin
      n.active = 1'b1;
      n.count = 7'h00;
      n.sum = 23'h000000;
      case (sampleMeanSelect)
        `MEAN_NONE: begin n.target = `COUNT_1; n.shift = `SHIFT_1; end
        `MEAN_8: begin n.target = `COUNT_8; n.shift = `SHIFT_8; end
        `MEAN_32: begin n.target = `COUNT_32; n.shift = `SHIFT_32; end
        default: begin n.target = `COUNT_64; n.shift = `SHIFT_64; end
      endcase
    end else if (q.active && sample.valid) begin
      n.sum = sumNext;
      n.count = q.count + 7'h01;
      // The result is released only when the whole block is in.
      if (n.count == q.target) begin
        n.active = 1'b0;
        n.meanValid = 1'b1;
        n.mean = 16'($signed(sumNext) >>> q.shift);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign needMore = q.active;
  assign meanValid = q.meanValid;
  assign mean = q.mean;
endmodule // sample_averager

// *** tb.sv ***
// Self-checking testbench for the sensor control and status logic.
`timescale 1ns/1ps
`include "temp_cfg_defines.svh"
module tb;
  import temp_cfg_pkg::*;
  logic ref_clk, rst, nvBusy, alarmPin, convStart;
  reg_req_t regReq;
  sample_t sample;
  logic [15:0] nvStartupImage, highLimit, lowLimit, regRdata, feBase, q;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam int CYC_FAST = 40;
  // The front end model answers after its default delay: one raw sample every 8 cycles.
  localparam int SAMPLE_TRIP = 8;
  temp_sensor_config_control #(.CYC_15P5MS(CYC_FAST), .CYC_125MS(80), .CYC_500MS(160),
    .CYC_1S(200), .CYC_SOFT_RESET(20)) u_temp_sensor_config_control (.ref_clk(ref_clk), .rst(rst),
    .regReq(regReq), .nvBusy(nvBusy), .nvStartupImage(nvStartupImage), .sample(sample),
    .highLimit(highLimit), .lowLimit(lowLimit), .regRdata(regRdata), .alarmPin(alarmPin),
    .convStart(convStart));
  fe_model u_fe_model (.ref_clk(ref_clk), .rst(rst), .convStart(convStart), .base(feBase),
    .sample(sample));
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    if (errCount == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      report_and_stop;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      errCount++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkPin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %0t alarm pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regReq = '{write: 1'h1, read: 1'h0, addr: a, wdata: d};
    cyc(1);
    regReq.write = 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input int n, output logic [15:0] d);
    regReq.addr = a;
    regReq.read = 1'h1;
    cyc(n);
    regReq.read = 1'h0;
    cyc(1);
    d = regRdata;
  endtask
  task automatic waitPin(input logic v);
    int k;
    k = 0;
    while (alarmPin !== v && k < 300) begin
      cyc(1);
      k++;
    end
    chkPin(alarmPin, v);
  endtask
  task automatic t_reset;
    rd(`CFG_ADDR, 1, q);
    chk(q, `CFG_RESET, 16'hFFFF);
    rd(`TEMP_ADDR, 1, q);
    chk(q, `TEMP_RESET, 16'hFFFF);
  endtask
  task automatic t_alert;
    waitPin(1'h0);
    rd(`CFG_ADDR, 1, q);
    chk(q, 16'hA220, 16'hFFFF);
    cyc(3);
    chkPin(alarmPin, 1'h1);
    rd(`CFG_ADDR, 1, q);
    chk(q, `CFG_RESET, 16'hFFFF);
    rd(`TEMP_ADDR, 1, q);
    chk(q, 16'h0201, 16'hFFFF);
  endtask
  task automatic t_modes;
    logic [1:0] mm;
    for (int m = 2; m < 6; m++) begin
      mm = 2'(m);
      wr(`CFG_ADDR, 16'h0020 | {4'h0, mm, 10'h000});
      rd(`CFG_ADDR, 1, q);
      chk(q, {4'h0, (mm == 2'h2) ? 2'h0 : mm, 10'h020}, 16'h0FFF);
    end
    // Power down starts no conversion, so the pin and the flags stay idle.
    cyc(80);
    chkPin(alarmPin, 1'h1);
    rd(`CFG_ADDR, 1, q);
    chk(q, 16'h0420, 16'hFFFF);
  endtask
  task automatic t_therm;
    wr(`CFG_ADDR, 16'h0C10);
    waitPin(1'h0);
    rd(`CFG_ADDR, 2, q);
    chk(q, 16'h8410, 16'hFFFF);
    feBase = 16'h0080;
    lowLimit = 16'h0100;
    wr(`CFG_ADDR, 16'h0C10);
    waitPin(1'h1);
    rd(`CFG_ADDR, 1, q);
    chk(q, 16'h2410, 16'hFFFF);
  endtask
  task automatic t_ready_pin;
    wr(`CFG_ADDR, 16'h0C0C);
    cyc(2);
    chkPin(alarmPin, 1'h0);
    waitPin(1'h1);
    rd(`TEMP_ADDR, 1, q);
    chk(q, 16'h0080, 16'hFFFD);
    cyc(2);
    chkPin(alarmPin, 1'h0);
  endtask
  task automatic t_busy_soft;
    nvBusy = 1'h1;
    cyc(1);
    rd(`CFG_ADDR, 1, q);
    chk(q, 16'h1000, 16'h1000);
    rd(`UNLOCK_ADDR, 1, q);
    chk(q, 16'h4000, 16'hFFFF);
    rd(4'h2, 1, q);
    chk(q, `READ_ZERO, 16'hFFFF);
    nvBusy = 1'h0;
    nvStartupImage = 16'h0E20;
    wr(`CFG_ADDR, 16'h0002);
    cyc(4);
    rd(`TEMP_ADDR, 1, q);
    chk(q, `READ_ZERO, 16'hFFFF);
    cyc(30);
    rd(`CFG_ADDR, 1, q);
    chk(q, 16'h0620, 16'hFFFF);
    rd(`TEMP_ADDR, 1, q);
    chk(q, `TEMP_RESET, 16'hFFFF);
  endtask
  // Measures the gap between two data ready rises once the written settings are in force.
  task automatic t_period(input logic [15:0] cfg, input int expGap);
    int k;
    wr(`CFG_ADDR, cfg);
    waitPin(1'h1);
    rd(`TEMP_ADDR, 1, q);
    waitPin(1'h1);
    rd(`TEMP_ADDR, 1, q);
    k = 2;
    while (alarmPin !== 1'h1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk(16'(k), 16'(expGap), 16'hFFFF);
  endtask
  initial begin
    rst = 1'h1;
    regReq = '0;
    nvBusy = 1'h0;
    nvStartupImage = `CFG_RESET;
    highLimit = 16'h0100;
    lowLimit = 16'h8000;
    feBase = 16'h0200;
    cyc(20);
    rst = 1'h0;
    t_reset;
    t_alert;
    t_modes;
    t_therm;
    t_ready_pin;
    t_busy_soft;
    t_period(16'h000C, CYC_FAST);
    t_period(16'h004C, `COUNT_32 * SAMPLE_TRIP + 2);
    report_and_stop;
  end
endmodule // tb

// *** temp_cfg_defines.svh ***
// Named constants for the sensor control and status logic.
`ifndef TEMP_CFG_DEFINES_SVH
`define TEMP_CFG_DEFINES_SVH

`define TEMP_ADDR 4'h0
`define CFG_ADDR 4'h1
`define UNLOCK_ADDR 4'h4

`define CFG_RESET 16'h0220
`define TEMP_RESET 16'h8000
`define READ_ZERO 16'h0000

`define BIT_HIGH 15
`define BIT_LOW 14
`define BIT_READY 13
`define BIT_BUSY 12
`define BIT_UNLOCK_BUSY 14
`define BIT_SOFT_RESET 1
`define SET_MSB 11
`define SET_LSB 2

`define MODE_FREE 2'h0
`define MODE_DOWN 2'h1
`define MODE_ALT 2'h2
`define MODE_SINGLE 2'h3

`define MEAN_NONE 2'h0
`define MEAN_8 2'h1
`define MEAN_32 2'h2
`define MEAN_64 2'h3
`define COUNT_1 7'h01
`define COUNT_8 7'h08
`define COUNT_32 7'h20
`define COUNT_64 7'h40
`define SHIFT_1 3'h0
`define SHIFT_8 3'h3
`define SHIFT_32 3'h5
`define SHIFT_64 3'h6

`define CLK_MHZ 200
`define T_15P5MS_US 15500
`define T_125MS_US 125000
`define T_250MS_US 250000
`define T_500MS_US 500000
`define T_1S_US 1000000
`define T_4S_US 4000000
`define T_8S_US 8000000
`define T_16S_US 16000000
`define T_SOFT_RESET_US 2000

`endif

// *** temp_cfg_monitor.sv ***
// Checker for the register and conversion behaviour at the block's ports.
`timescale 1ns/1ps
`include "temp_cfg_defines.svh"
module temp_cfg_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input temp_cfg_pkg::reg_req_t regReq,
  input wire logic nvBusy,
  input wire logic [15:0] nvStartupImage,
  input temp_cfg_pkg::sample_t sample,
  input wire logic [15:0] highLimit,
  input wire logic [15:0] lowLimit,
  input wire logic [15:0] regRdata,
  input wire logic alarmPin,
  input wire logic convStart
);
  import temp_cfg_pkg::*;
  logic rdCfg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  assign rdCfg = regReq.read && regReq.addr == `CFG_ADDR;
  low_bits_a: assert property (rdCfg |=> regRdata[1:0] == 2'h0 || $stable(regRdata))
    else $error("config read shows set low bits");
  mode_code_a: assert property (rdCfg |=> regRdata[11:10] != 2'h2 || $stable(regRdata))
    else $error("mode reads back as 10");
  busy_bit_a: assert property (rdCfg |=> regRdata[12] == $past(nvBusy) || $stable(regRdata))
    else $error("busy bit differs from memory busy");
  busy_mirror_a: assert property (regReq.read && regReq.addr == `UNLOCK_ADDR |=>
    regRdata == {1'h0, $past(nvBusy), 14'h0000} || $stable(regRdata))
    else $error("unlock word differs from busy mirror");
  therm_low_a: assert property (rdCfg |=> !(regRdata[4] && regRdata[14]))
    else $error("low flag set in therm mode");
  start_gap_a: assert property (convStart |=> !convStart [*2])
    else $error("conversion requests too close");
  read_clears_a: assert property (rdCfg ##1 (rdCfg && !$past(sample.valid, 2))
    |=> !regRdata[13] && !regRdata[14])
    else $error("flags survive a config read");
  therm_hold_a: assert property (rdCfg ##1 (rdCfg && regRdata[4] && regRdata[15]
    && !$past(sample.valid, 2)) |=> regRdata[15])
    else $error("therm high flag cleared by read");
  cover property (regReq.write && regReq.addr == `CFG_ADDR);
  cover property (convStart ##[1:20] sample.valid);
  cover property (rdCfg ##1 rdCfg);
endmodule // temp_cfg_monitor
bind temp_sensor_config_control temp_cfg_monitor u_temp_cfg_monitor (
  .ref_clk(ref_clk),
  .rst(rst),
  .regReq(regReq),
  .nvBusy(nvBusy),
  .nvStartupImage(nvStartupImage),
  .sample(sample),
  .highLimit(highLimit),
  .lowLimit(lowLimit),
  .regRdata(regRdata),
  .alarmPin(alarmPin),
  .convStart(convStart)
);

// *** temp_cfg_pkg.sv ***
// Types shared by the sensor control and status logic.
package temp_cfg_pkg;

  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_CONV = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_SRST = 5'b10000
  } ctl_state_t;

  // Writable fields, in register order from bit 11 down to bit 2.
  typedef struct packed {
    logic [1:0] conversionModeSelect;
    logic [2:0] cyclePeriodSelect;
    logic [1:0] sampleMeanSelect;
    logic thermOrAlertSelect;
    logic alarmPinLevelSense;
    logic alarmPinSourceSelect;
  } settings_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sample_t;

  typedef struct packed {
    ctl_state_t state;
    settings_t set;
    logic highFlag;
    logic lowFlag;
    logic dataReady;
    logic pending;
    logic [15:0] result;
    logic [15:0] rdata;
    logic alarmPin;
    logic convStart;
    logic [31:0] srCount;
  } ctl_t;

  typedef struct packed {
    logic active;
    logic [6:0] target;
    logic [2:0] shift;
    logic [6:0] count;
    logic [22:0] sum;
    logic meanValid;
    logic [15:0] mean;
  } avg_t;

  typedef struct packed {
    logic [31:0] count;
  } timer_t;

endpackage

// *** temp_sensor_config_control.sv ***
// Control and status register logic of the temperature sensor.
// How it works
// - Alert mode: high flag sets, cleared on config read.
// - Therm mode: high flag clears below hysteresis only.
// - Low flag alert mode only; reads zero otherwise.
// - Data ready sets on update, clears on temp and config reads.
// - Busy flag shows memory programming or loading.
// - Mode 00/10 free, 01 down, 11 single.
// - Cycle period field resets to 100.
// - Block average of 1, 8, 32, 64.
// - Result updates only after the full block.
// - Bit 4 picks therm or alert behaviour.
// - Bit 3 sets alarm pin active level.
// - Bit 2 picks data ready or limit flags.
// - Writing bit 1 gives 2ms reset; reads zero.
// - Startup image never restores the upper mode bit.
// - Factory startup value is 0220.
// - Free running cycle times per period table.
// - Long averaging runs cycles back to back.
// - Result two's complement, reads 8000 until first.
// - Busy flag mirrored into unlock register bit 14.
`timescale 1ns/1ps
`include "temp_cfg_defines.svh"
module temp_sensor_config_control #(
  parameter logic [31:0] CYC_15P5MS = 32'(64'(`T_15P5MS_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_125MS = 32'(64'(`T_125MS_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_250MS = 32'(64'(`T_250MS_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_500MS = 32'(64'(`T_500MS_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_1S = 32'(64'(`T_1S_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_4S = 32'(64'(`T_4S_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_8S = 32'(64'(`T_8S_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_16S = 32'(64'(`T_16S_US) * 64'(`CLK_MHZ)),
  parameter logic [31:0] CYC_SOFT_RESET = 32'(64'(`T_SOFT_RESET_US) * 64'(`CLK_MHZ))
) (
  input wire logic ref_clk,
  input wire logic rst,
  input temp_cfg_pkg::reg_req_t regReq,
  input wire logic nvBusy,
  input wire logic [15:0] nvStartupImage,
  input temp_cfg_pkg::sample_t sample,
  input wire logic [15:0] highLimit,
  input wire logic [15:0] lowLimit,
  output logic [15:0] regRdata,
  output logic alarmPin,
  output logic convStart
);
  import temp_cfg_pkg::*;

  ctl_t q;
  ctl_t n;
  logic startCycle;
  logic timerExpired;
  logic needMore;
  logic meanValid;
  logic [15:0] mean;
  logic [31:0] periodCycles;
  logic [15:0] cfgWord;

  // Period from the table: the averaging floor lifts the short settings.
  function automatic logic [31:0] cyclePeriod(input logic [2:0] sel, input logic [1:0] avg);
    logic [31:0] base;
    logic [31:0] floor;
    case (sel)
      3'h0: base = CYC_15P5MS;
      3'h1: base = CYC_125MS;
      3'h2: base = CYC_250MS;
      3'h3: base = CYC_500MS;
      3'h4: base = CYC_1S;
      3'h5: base = CYC_4S;
      3'h6: base = CYC_8S;
      default: base = CYC_16S;
    endcase
    case (avg)
      `MEAN_NONE: floor = 32'h0;
      `MEAN_8: floor = CYC_125MS;
      `MEAN_32: floor = CYC_500MS;
      default: floor = CYC_1S;
    endcase
    cyclePeriod = (base > floor) ? base : floor;
  endfunction

  // Mode 10 is folded onto free running so it reads back as 00.
  function automatic settings_t takeSettings(input logic [15:0] word);
    settings_t s;
    s = settings_t'(word[`SET_MSB:`SET_LSB]);
    if (s.conversionModeSelect == `MODE_ALT) begin
      s.conversionModeSelect = `MODE_FREE;
    end
    takeSettings = s;
  endfunction

  // Pin level from the selected source and polarity.
  function automatic logic pinLevel(input ctl_t s);
    logic src;
    src = s.set.alarmPinSourceSelect ? s.dataReady : (s.highFlag | s.lowFlag);
    pinLevel = s.set.alarmPinLevelSense ? src : ~src;
  endfunction

  // Taken from the next settings, so a cycle started by a write uses the written period.
  assign periodCycles = cyclePeriod(n.set.cyclePeriodSelect, n.set.sampleMeanSelect);
  assign cfgWord = {q.highFlag, q.lowFlag & ~q.set.thermOrAlertSelect, q.dataReady,
                    nvBusy, q.set, 2'b00};

  always_comb begin
    n = q;
    n.convStart = 1'b0;
    startCycle = 1'b0;

    // Reads clear first so that a hardware set in the same cycle wins.
    if (regReq.read && q.state != ST_SRST) begin
      case (regReq.addr)
        `TEMP_ADDR: begin
          n.rdata = q.result;
          n.dataReady = 1'b0;
        end
        `CFG_ADDR: begin
          n.rdata = cfgWord;
          n.dataReady = 1'b0;
          if (!q.set.thermOrAlertSelect) begin
            n.highFlag = 1'b0;
            n.lowFlag = 1'b0;
          end
        end
        `UNLOCK_ADDR: begin
          n.rdata = `READ_ZERO;
          n.rdata[`BIT_UNLOCK_BUSY] = nvBusy;
        end
        default: n.rdata = `READ_ZERO;
      endcase
    end

    if (regReq.write && regReq.addr == `CFG_ADDR && q.state != ST_SRST) begin
      n.set = takeSettings(regReq.wdata);
    end

    case (q.state)
      ST_LOAD: begin
        // Wait for the startup image to finish loading, then adopt it.
        if (!nvBusy) begin
          n.set = takeSettings(nvStartupImage);
          n.set.conversionModeSelect[1] = 1'b0;
          n.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (n.set.conversionModeSelect != `MODE_DOWN) begin
          startCycle = 1'b1;
          n.state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sample.valid) begin
          n.pending = 1'b0;
        end
        if (meanValid) begin
          n.result = mean;
          n.dataReady = 1'b1;
          if (n.set.thermOrAlertSelect) begin
            if ($signed(mean) > $signed(highLimit)) begin
              n.highFlag = 1'b1;
            end else if ($signed(mean) < $signed(lowLimit)) begin
              n.highFlag = 1'b0;
            end
          end else begin
            if ($signed(mean) > $signed(highLimit)) begin
              n.highFlag = 1'b1;
            end
            if ($signed(mean) < $signed(lowLimit)) begin
              n.lowFlag = 1'b1;
            end
          end
          if (n.set.conversionModeSelect == `MODE_SINGLE) begin
            n.set.conversionModeSelect = `MODE_DOWN;
            n.state = ST_IDLE;
          end else begin
            n.state = ST_HOLD;
          end
        end else if (needMore && !q.pending && !sample.valid) begin
          n.convStart = 1'b1;
          n.pending = 1'b1;
        end
      end
      ST_HOLD: begin
        if (n.set.conversionModeSelect == `MODE_DOWN) begin
          n.state = ST_IDLE;
        end else if (timerExpired) begin
          // An overrun period has already expired, so no standby is added.
          startCycle = 1'b1;
          n.state = ST_CONV;
        end
      end
      ST_SRST: begin
        if (q.srCount == 32'h0) begin
          n.state = ST_LOAD;
        end else begin
          n.srCount = q.srCount - 32'h1;
        end
      end
      default: n.state = ST_LOAD;
    endcase

    if (regReq.write && regReq.addr == `CFG_ADDR && q.state != ST_SRST &&
        regReq.wdata[`BIT_SOFT_RESET]) begin
      n.state = ST_SRST;
      n.srCount = CYC_SOFT_RESET - 32'h1;
      n.highFlag = 1'b0;
      n.lowFlag = 1'b0;
      n.dataReady = 1'b0;
      n.pending = 1'b0;
      n.convStart = 1'b0;
      n.result = `TEMP_RESET;
      startCycle = 1'b0;
    end

    if (n.set.thermOrAlertSelect) begin
      n.lowFlag = 1'b0;
    end
    n.alarmPin = pinLevel(n);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q.state <= ST_LOAD;
      q.set <= settings_t'(10'(`CFG_RESET >> `SET_LSB));
      q.highFlag <= 1'b0;
      q.lowFlag <= 1'b0;
      q.dataReady <= 1'b0;
      q.pending <= 1'b0;
      q.result <= `TEMP_RESET;
      q.rdata <= `READ_ZERO;
      q.alarmPin <= 1'b1;
      q.convStart <= 1'b0;
      q.srCount <= 32'h0;
    end else begin
      q <= n;
    end
  end

  sample_averager averager (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(startCycle),
    .sampleMeanSelect(n.set.sampleMeanSelect),
    .sample(sample),
    .needMore(needMore),
    .meanValid(meanValid),
    .mean(mean)
  );

  cycle_timer timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(startCycle),
    .target(periodCycles),
    .expired(timerExpired)
  );

  assign regRdata = q.rdata;
  assign alarmPin = q.alarmPin;
  assign convStart = q.convStart;
endmodule // temp_sensor_config_control
